// *** rtl/fqs_top.sv ***
// Purpose: Command interface with query table, security area and
//   erase suspend sequencing.
// Assumes: Bus writes and reads are single-cycle strobes in clk_sys.
// Notes: Array contents are outside; this block only reports mode.
`timescale 1ns/1ns
`default_nettype none
module fqs_top #(
  parameter logic [63:0] UNIQUE_NUMBER = 64'h0123_4567_89ab_cdef
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic supply_ok,
  input wire logic block_locked,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic array_read,
  output logic program_busy,
  output logic erase_busy,
  output logic erase_paused_state,
  output logic [7:0] status_word
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fqs_pkg::fqs_mode_type mode_reg;
  logic [15:0] rom_data;
  logic [15:0] sec_data;
  logic sec_wr;
  logic rd_pend_reg;
  logic rd_sec_reg;
  logic rd_query_reg;
  logic rd_status_reg;
  logic [1:0] multi_left_reg;
  logic [7:0] multi_base_reg;
  logic multi_first_reg;
  logic multi_quad_reg;
  logic [fqs_pkg::BUSY_WIDTH-1:0] busy_cnt_reg;
  logic [fqs_pkg::BUSY_WIDTH-1:0] suspend_cnt_reg;
  logic suspend_req_reg;
  logic controller_ready_flag;
  logic erase_suspended_flag;
  logic protected_block_flag;
  logic supply_invalid_flag;
  logic program_error_flag;
  logic erase_error_flag;
  logic error_any;
  logic [7:0] cmd;

  assign cmd = wr_data[7:0];

  function automatic logic is_cmd(input logic [7:0] code, input logic [7:0] want);
    is_cmd = (code == want);
  endfunction : is_cmd

  // ----------------------------------------------------------------
  // Table stores
  // ----------------------------------------------------------------
  fqs_query_rom u_rom (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .addr(addr),
    .data(rom_data)
  );

  assign sec_wr = wr_stb && clk_en && (mode_reg == fqs_pkg::FQS_PROG_SETUP)
                  && (addr >= fqs_pkg::OFF_PROTECTION_WORD)
                  && (addr < 8'h8a) && !error_any;

  fqs_security_mem #(
    .UNIQUE_NUMBER(UNIQUE_NUMBER)
  ) u_sec (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .rd_index(4'(addr - fqs_pkg::OFF_PROTECTION_WORD)),
    .wr_en(sec_wr),
    .wr_index(4'(addr - fqs_pkg::OFF_PROTECTION_WORD)),
    .wr_data(wr_data),
    .rd_data(sec_data)
  );

  assign error_any = protected_block_flag | supply_invalid_flag | program_error_flag
                     | erase_error_flag;

  // ----------------------------------------------------------------
  // Command decoding
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mode_reg <= fqs_pkg::FQS_READ_ARRAY;
      multi_left_reg <= 2'h0;
      multi_base_reg <= 8'h00;
      multi_first_reg <= 1'b0;
      multi_quad_reg <= 1'b0;
    end else if (clk_en && wr_stb) begin
      case (mode_reg)
        fqs_pkg::FQS_PROG_SETUP: begin
          mode_reg <= fqs_pkg::FQS_READ_STATUS;
        end
        fqs_pkg::FQS_ERASE_SETUP: begin
          mode_reg <= fqs_pkg::FQS_READ_STATUS;
        end
        fqs_pkg::FQS_MULTI_SETUP: begin
          // Words beyond the first must share the upper address bits.
          if (multi_left_reg == 2'h0) begin
            mode_reg <= fqs_pkg::FQS_READ_STATUS;
          end
          // The command word carries no address, so the group is taken from the first data word.
          if (multi_first_reg) begin
            multi_base_reg <= addr;
          end
          multi_first_reg <= 1'b0;
          multi_left_reg <= multi_left_reg - 2'h1;
        end
        default: begin
          if (is_cmd(cmd, fqs_pkg::CMD_QUERY)) begin
            mode_reg <= fqs_pkg::FQS_READ_QUERY;
          end else if (is_cmd(cmd, fqs_pkg::CMD_READ_ARRAY)) begin
            mode_reg <= fqs_pkg::FQS_READ_ARRAY;
          end else if (is_cmd(cmd, fqs_pkg::CMD_READ_STATUS)
                       || is_cmd(cmd, fqs_pkg::CMD_SUSPEND)
                       || is_cmd(cmd, fqs_pkg::CMD_RESUME)) begin
            mode_reg <= fqs_pkg::FQS_READ_STATUS;
          end else if (is_cmd(cmd, fqs_pkg::CMD_CLEAR_STATUS)) begin
            mode_reg <= fqs_pkg::FQS_READ_ARRAY;
          end else if ((is_cmd(cmd, fqs_pkg::CMD_PROG_SETUP)
                        || is_cmd(cmd, fqs_pkg::CMD_PROG_SETUP_ALT)) && !program_busy) begin
            mode_reg <= fqs_pkg::FQS_PROG_SETUP;
          end else if (is_cmd(cmd, fqs_pkg::CMD_ERASE_SETUP) && !erase_busy
                       && !erase_paused_state) begin
            mode_reg <= fqs_pkg::FQS_ERASE_SETUP;
          end else if (is_cmd(cmd, fqs_pkg::CMD_DOUBLE_PROG) && !program_busy) begin
            mode_reg <= fqs_pkg::FQS_MULTI_SETUP;
            multi_left_reg <= 2'h1;
            multi_first_reg <= 1'b1;
            multi_quad_reg <= 1'b0;
          end else if (is_cmd(cmd, fqs_pkg::CMD_QUAD_PROG) && !program_busy) begin
            mode_reg <= fqs_pkg::FQS_MULTI_SETUP;
            multi_left_reg <= 2'h3;
            multi_first_reg <= 1'b1;
            multi_quad_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Program and erase controller
  // ----------------------------------------------------------------
  // Errors block new operations until status is cleared.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      program_busy <= 1'b0;
      erase_busy <= 1'b0;
      erase_paused_state <= 1'b0;
      busy_cnt_reg <= '0;
      suspend_req_reg <= 1'b0;
      suspend_cnt_reg <= '0;
    end else if (clk_en) begin
      if (program_busy) begin
        if (busy_cnt_reg == '0) begin
          program_busy <= 1'b0;
        end else begin
          busy_cnt_reg <= busy_cnt_reg - 1'b1;
        end
      end else if (erase_busy) begin
        if (suspend_req_reg) begin
          if (suspend_cnt_reg == '0) begin
            erase_busy <= 1'b0;
            erase_paused_state <= 1'b1;
            suspend_req_reg <= 1'b0;
          end else begin
            suspend_cnt_reg <= suspend_cnt_reg - 1'b1;
          end
        end
        if (busy_cnt_reg == '0) begin
          // Finishing first means the suspend found nothing left to pause.
          erase_busy <= 1'b0;
          erase_paused_state <= 1'b0;
          suspend_req_reg <= 1'b0;
        end else begin
          busy_cnt_reg <= busy_cnt_reg - 1'b1;
        end
      end
      if (wr_stb && !error_any) begin
        if (mode_reg == fqs_pkg::FQS_PROG_SETUP && !sec_wr
            || mode_reg == fqs_pkg::FQS_MULTI_SETUP && multi_left_reg == 2'h0) begin
          program_busy <= 1'b1;
          busy_cnt_reg <= fqs_pkg::BUSY_WIDTH'(fqs_pkg::PROGRAM_CYCLES);
        end else if (mode_reg == fqs_pkg::FQS_ERASE_SETUP
                     && is_cmd(cmd, fqs_pkg::CMD_RESUME)) begin
          erase_busy <= 1'b1;
          busy_cnt_reg <= fqs_pkg::BUSY_WIDTH'(fqs_pkg::ERASE_CYCLES);
        end else if (mode_reg != fqs_pkg::FQS_PROG_SETUP
                     && mode_reg != fqs_pkg::FQS_MULTI_SETUP
                     && mode_reg != fqs_pkg::FQS_ERASE_SETUP) begin
          if (is_cmd(cmd, fqs_pkg::CMD_SUSPEND) && erase_busy) begin
            suspend_req_reg <= 1'b1;
            suspend_cnt_reg <= fqs_pkg::BUSY_WIDTH'(fqs_pkg::SUSPEND_CYCLES);
          end else if (is_cmd(cmd, fqs_pkg::CMD_RESUME) && erase_paused_state
                       && !program_busy) begin
            erase_paused_state <= 1'b0;
            erase_busy <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  assign controller_ready_flag = !program_busy && !(erase_busy);
  assign erase_suspended_flag = erase_paused_state;

  // Error flags stay set until clear status; a new error in the same
  // cycle as the clear survives it.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      protected_block_flag <= 1'b0;
      supply_invalid_flag <= 1'b0;
      program_error_flag <= 1'b0;
      erase_error_flag <= 1'b0;
    end else if (clk_en) begin
      if (wr_stb && mode_reg != fqs_pkg::FQS_PROG_SETUP
          && mode_reg != fqs_pkg::FQS_MULTI_SETUP
          && mode_reg != fqs_pkg::FQS_ERASE_SETUP
          && is_cmd(cmd, fqs_pkg::CMD_CLEAR_STATUS)) begin
        protected_block_flag <= 1'b0;
        supply_invalid_flag <= 1'b0;
        program_error_flag <= 1'b0;
        erase_error_flag <= 1'b0;
      end
      if (wr_stb && (mode_reg == fqs_pkg::FQS_PROG_SETUP
                     || mode_reg == fqs_pkg::FQS_ERASE_SETUP
                     || mode_reg == fqs_pkg::FQS_MULTI_SETUP)) begin
        if (block_locked) begin
          protected_block_flag <= 1'b1;
        end
        if (!supply_ok) begin
          supply_invalid_flag <= 1'b1;
        end
        if (mode_reg == fqs_pkg::FQS_MULTI_SETUP && !multi_first_reg
            && (addr[7:2] != multi_base_reg[7:2]
                || !multi_quad_reg && addr[1] != multi_base_reg[1])) begin
          program_error_flag <= 1'b1;
        end
        if (mode_reg == fqs_pkg::FQS_ERASE_SETUP && !is_cmd(cmd, fqs_pkg::CMD_RESUME)) begin
          erase_error_flag <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    status_word = 8'h00;
    status_word[fqs_pkg::SR_CONTROLLER_READY] = controller_ready_flag;
    status_word[fqs_pkg::SR_ERASE_SUSPENDED] = erase_suspended_flag;
    status_word[fqs_pkg::SR_ERASE_ERROR] = erase_error_flag;
    status_word[fqs_pkg::SR_PROGRAM_ERROR] = program_error_flag;
    status_word[fqs_pkg::SR_SUPPLY_INVALID] = supply_invalid_flag;
    status_word[fqs_pkg::SR_PROTECTED_BLOCK] = protected_block_flag;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // The stores answer one cycle after the strobe, so the source is
  // remembered alongside and selected then.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_pend_reg <= 1'b0;
      rd_sec_reg <= 1'b0;
      rd_query_reg <= 1'b0;
      rd_status_reg <= 1'b0;
    end else if (clk_en) begin
      rd_pend_reg <= rd_stb;
      rd_query_reg <= (mode_reg == fqs_pkg::FQS_READ_QUERY);
      // Bounded so that high offsets do not alias back onto the protection word.
      rd_sec_reg <= (addr >= fqs_pkg::OFF_PROTECTION_WORD) && (addr < 8'h8a);
      rd_status_reg <= (mode_reg == fqs_pkg::FQS_READ_STATUS);
    end
  end

  always_comb begin
    rd_data = 16'h0000;
    if (rd_query_reg) begin
      rd_data = {8'h00, rd_sec_reg ? sec_data[7:0] : rom_data[7:0]};
      if (rd_sec_reg) begin
        rd_data = sec_data;
      end
    end else if (rd_status_reg) begin
      rd_data = {8'h00, status_word};
    end
  end

  assign rd_valid = rd_pend_reg;
  assign array_read = (mode_reg == fqs_pkg::FQS_READ_ARRAY);
endmodule : fqs_top
`default_nettype wire

// *** rtl/fqs_pkg.sv ***
// Purpose: Constants for the flash query and sequencing block.
// Assumes: 16-bit data bus, word addressing, one system clock.
// Notes: Identity-free; the unique number is a parameter of the top.
package fqs_pkg;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'hd0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_DOUBLE_PROG = 8'h30;
  localparam logic [7:0] CMD_QUAD_PROG = 8'h55;
  // ----------------------------------------------------------------
  // Extended query table offsets and values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SIGNATURE_0 = 8'h39;
  localparam logic [7:0] OFF_SIGNATURE_1 = 8'h3a;
  localparam logic [7:0] OFF_SIGNATURE_2 = 8'h3b;
  localparam logic [7:0] OFF_MAJOR_VERSION = 8'h3c;
  localparam logic [7:0] OFF_MINOR_VERSION = 8'h3d;
  localparam logic [7:0] OFF_FEATURES_LO = 8'h3e;
  localparam logic [7:0] OFF_FEATURES_HI = 8'h3f;
  localparam logic [7:0] OFF_AFTER_SUSPEND = 8'h42;
  localparam logic [7:0] OFF_BLOCK_PROTECT = 8'h43;
  localparam logic [7:0] OFF_CORE_SUPPLY = 8'h45;
  localparam logic [7:0] OFF_PROG_SUPPLY = 8'h46;
  localparam logic [7:0] OFF_PAGE_SIZE = 8'h4c;
  localparam logic [7:0] OFF_SYNC_COUNT = 8'h4d;
  localparam logic [7:0] OFF_SYNC_CFG_1 = 8'h4e;
  localparam logic [7:0] OFF_SYNC_CFG_2 = 8'h4f;
  localparam logic [7:0] OFF_SYNC_CFG_3 = 8'h50;
  localparam logic [7:0] OFF_MAX_CLOCK = 8'h51;
  localparam logic [7:0] OFF_STALL_SUPPORT = 8'h52;
  localparam logic [7:0] OFF_PROTECTION_WORD = 8'h80;
  localparam logic [7:0] OFF_UNIQUE_NUMBER = 8'h81;
  localparam logic [7:0] OFF_USER_OTP = 8'h86;
  localparam int SECURITY_WORDS = 4;
  localparam logic [15:0] VAL_SIGNATURE_0 = 16'h0050;
  localparam logic [15:0] VAL_SIGNATURE_1 = 16'h0052;
  localparam logic [15:0] VAL_SIGNATURE_2 = 16'h0049;
  localparam logic [15:0] VAL_MAJOR_VERSION = 16'h0031;
  localparam logic [15:0] VAL_MINOR_VERSION = 16'h0030;
  localparam logic [15:0] VAL_FEATURES_LO = 16'h00e6;
  localparam logic [15:0] VAL_FEATURES_HI = 16'h0003;
  localparam logic [15:0] VAL_AFTER_SUSPEND = 16'h0001;
  localparam logic [15:0] VAL_BLOCK_PROTECT = 16'h0003;
  localparam logic [15:0] VAL_CORE_SUPPLY = 16'h0018;
  localparam logic [15:0] VAL_PROG_SUPPLY = 16'h00c0;
  localparam logic [15:0] VAL_PAGE_SIZE = 16'h0003;
  localparam logic [15:0] VAL_SYNC_COUNT = 16'h0003;
  localparam logic [15:0] VAL_SYNC_CFG_1 = 16'h0001;
  localparam logic [15:0] VAL_SYNC_CFG_2 = 16'h0002;
  localparam logic [15:0] VAL_SYNC_CFG_3 = 16'h0007;
  localparam logic [15:0] VAL_MAX_CLOCK = 16'h0036;
  localparam logic [15:0] VAL_STALL_SUPPORT = 16'h0001;
  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int SR_PROTECTED_BLOCK = 1;
  localparam int SR_SUPPLY_INVALID = 3;
  localparam int SR_PROGRAM_ERROR = 4;
  localparam int SR_ERASE_ERROR = 5;
  localparam int SR_ERASE_SUSPENDED = 6;
  localparam int SR_CONTROLLER_READY = 7;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SUSPEND_LATENCY_NS = 50;
  localparam int SUSPEND_CYCLES = (SUSPEND_LATENCY_NS * CLK_MHZ + 999) / 1000;
  localparam int PROGRAM_CYCLES = 16;
  localparam int ERASE_CYCLES = 64;
  localparam int BUSY_WIDTH = 8;
  // ----------------------------------------------------------------
  // Command interface state
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    FQS_READ_ARRAY = 6'b000001,
    FQS_READ_QUERY = 6'b000010,
    FQS_READ_STATUS = 6'b000100,
    FQS_PROG_SETUP = 6'b001000,
    FQS_ERASE_SETUP = 6'b010000,
    FQS_MULTI_SETUP = 6'b100000
  } fqs_mode_type;
endpackage : fqs_pkg

// *** rtl/fqs_security_mem.sv ***
// Purpose: Security area store with registered read data.
// Assumes: Factory contents come in as parameters, user words are OTP.
// Notes: A write can only clear bits, as one-time cells do.
`timescale 1ns/1ns
`default_nettype none
module fqs_security_mem #(
  parameter logic [63:0] UNIQUE_NUMBER = 64'h0123_4567_89ab_cdef
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [3:0] rd_index,
  input wire logic wr_en,
  input wire logic [3:0] wr_index,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data
);
  logic [15:0] otp_reg [0:fqs_pkg::SECURITY_WORDS-1];
  logic [15:0] protect_reg;

  // ----------------------------------------------------------------
  // Programming: bits only go from one to zero.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int i = 0; i < fqs_pkg::SECURITY_WORDS; i++) begin
        otp_reg[i] <= 16'hffff;
      end
      protect_reg <= 16'h0006;
    end else if (clk_en && wr_en) begin
      if (wr_index == 4'h0) begin
        protect_reg <= protect_reg & {13'h0000, wr_data[2:1], 1'b0} | 16'h0000;
      end else if (wr_index >= 4'h6 && wr_index <= 4'h9) begin
        if (protect_reg[1]) begin
          otp_reg[2'(wr_index - 4'h6)] <= otp_reg[2'(wr_index - 4'h6)] & wr_data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_data <= 16'h0000;
    end else if (clk_en) begin
      case (rd_index)
        4'h0: rd_data <= {13'h0000, protect_reg[2:1], 1'b0};
        4'h1: rd_data <= UNIQUE_NUMBER[15:0];
        4'h2: rd_data <= UNIQUE_NUMBER[31:16];
        4'h3: rd_data <= UNIQUE_NUMBER[47:32];
        4'h4: rd_data <= UNIQUE_NUMBER[63:48];
        4'h6: rd_data <= otp_reg[0];
        4'h7: rd_data <= otp_reg[1];
        4'h8: rd_data <= otp_reg[2];
        4'h9: rd_data <= otp_reg[3];
        default: rd_data <= 16'h0000;
      endcase
    end
  end
endmodule : fqs_security_mem
`default_nettype wire

// *** rtl/fqs_query_rom.sv ***
// Purpose: Extended query table as a registered lookup.
// Assumes: Word offsets within the query space.
// Notes: Unlisted offsets read as zero.
`timescale 1ns/1ns
`default_nettype none
module fqs_query_rom (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  output logic [15:0] data
);
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      data <= 16'h0000;
    end else if (clk_en) begin
      case (addr)
        fqs_pkg::OFF_SIGNATURE_0: data <= fqs_pkg::VAL_SIGNATURE_0;
        fqs_pkg::OFF_SIGNATURE_1: data <= fqs_pkg::VAL_SIGNATURE_1;
        fqs_pkg::OFF_SIGNATURE_2: data <= fqs_pkg::VAL_SIGNATURE_2;
        fqs_pkg::OFF_MAJOR_VERSION: data <= fqs_pkg::VAL_MAJOR_VERSION;
        fqs_pkg::OFF_MINOR_VERSION: data <= fqs_pkg::VAL_MINOR_VERSION;
        fqs_pkg::OFF_FEATURES_LO: data <= fqs_pkg::VAL_FEATURES_LO;
        fqs_pkg::OFF_FEATURES_HI: data <= fqs_pkg::VAL_FEATURES_HI;
        fqs_pkg::OFF_AFTER_SUSPEND: data <= fqs_pkg::VAL_AFTER_SUSPEND;
        fqs_pkg::OFF_BLOCK_PROTECT: data <= fqs_pkg::VAL_BLOCK_PROTECT;
        fqs_pkg::OFF_CORE_SUPPLY: data <= fqs_pkg::VAL_CORE_SUPPLY;
        fqs_pkg::OFF_PROG_SUPPLY: data <= fqs_pkg::VAL_PROG_SUPPLY;
        fqs_pkg::OFF_PAGE_SIZE: data <= fqs_pkg::VAL_PAGE_SIZE;
        fqs_pkg::OFF_SYNC_COUNT: data <= fqs_pkg::VAL_SYNC_COUNT;
        fqs_pkg::OFF_SYNC_CFG_1: data <= fqs_pkg::VAL_SYNC_CFG_1;
        fqs_pkg::OFF_SYNC_CFG_2: data <= fqs_pkg::VAL_SYNC_CFG_2;
        fqs_pkg::OFF_SYNC_CFG_3: data <= fqs_pkg::VAL_SYNC_CFG_3;
        fqs_pkg::OFF_MAX_CLOCK: data <= fqs_pkg::VAL_MAX_CLOCK;
        fqs_pkg::OFF_STALL_SUPPORT: data <= fqs_pkg::VAL_STALL_SUPPORT;
        default: data <= 16'h0000;
      endcase
    end
  end
endmodule : fqs_query_rom
`default_nettype wire

// *** tb/fqs_chk.sv ***
// Purpose: Port-level checks on the flash query and sequencing top.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound into every fqs_top instance.
`timescale 1ns/1ns
`default_nettype none
module fqs_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic array_read,
  input wire logic program_busy,
  input wire logic erase_busy,
  input wire logic erase_paused_state,
  input wire logic [7:0] status_word
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic cmd_ok;
  assign cmd_ok = wr_stb && clk_en;
  chk_valid_after_read: assert property (rd_stb && clk_en |=> rd_valid)
    else $error("read strobe without answer");
  chk_valid_only_read: assert property (rd_valid |-> $past(rd_stb))
    else $error("answer without read strobe");
  chk_query_enter: assert property (cmd_ok && wr_data[7:0] == 8'h98 |=> !array_read)
    else $error("query command ignored");
  chk_array_return: assert property (cmd_ok && wr_data[7:0] == 8'hff && !program_busy
    && !erase_busy |=> array_read)
    else $error("read array command ignored");
  chk_array_zero: assert property (rd_valid && $past(array_read) |-> rd_data == 16'h0000)
    else $error("array mode read not zero");
  chk_query_low_byte: assert property (rd_valid && $past(addr) < 8'h80 |->
    rd_data[15:8] == 8'h00)
    else $error("query upper byte not zero");
  chk_suspend_ready: assert property (erase_busy && !erase_paused_state && cmd_ok
    && wr_data[7:0] == 8'hb0 |-> ##[1:8] status_word[7])
    else $error("suspend not completed in time");
  chk_paused_flag: assert property (erase_paused_state |-> status_word[6])
    else $error("suspended flag not shown");
  chk_busy_not_ready: assert property (program_busy |-> !status_word[7])
    else $error("ready while programming");
  cover property (rd_valid && rd_data == 16'h0050);
  cover property ($rose(erase_paused_state));
  cover property ($rose(status_word[4]));
endmodule : fqs_chk
bind fqs_top fqs_chk i_chk (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
  .rd_valid(rd_valid), .array_read(array_read), .program_busy(program_busy),
  .erase_busy(erase_busy), .erase_paused_state(erase_paused_state),
  .status_word(status_word));
`default_nettype wire

// *** tb/fqs_host.sv ***
// Purpose: Host model for the flash command bus.
// Assumes: One-cycle strobes launched on the falling edge.
// Notes: Released lines are inverted so stale values never look valid.
`timescale 1ns/1ns
`default_nettype none
module fqs_host (
  input wire logic clk_sys,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] addr,
  output logic [15:0] wr_data
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 8'h00;
    wr_data = 16'h0000;
  end
  // Every command passes here; burst codes are used unchanged.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    wr_stb = 1'b1;
    addr = a;
    wr_data = d;
    @(negedge clk_sys);
    wr_stb = 1'b0;
    addr = ~a;
    wr_data = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    rd_stb = 1'b1;
    addr = a;
    @(negedge clk_sys);
    rd_stb = 1'b0;
    addr = ~a;
    d = rd_valid ? rd_data : 16'hxxxx;
  endtask : rd
endmodule : fqs_host
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the flash query and sequencing top.
// Assumes: Security cells start erased.
// Notes: Error flags are checked after the double, quad and setup-error program sequences and after the final clear status.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [63:0] UNIQ = 64'h5a5a_1234_9876_c3c3; // Arbitrary value.
  localparam logic [15:0] Q_TAB [26] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0030,
    16'h00e6, 16'h0003, 16'h0, 16'h0, 16'h0001, 16'h0003, 16'h0, 16'h0018, 16'h00c0, 16'h0,
    16'h0, 16'h0, 16'h0, 16'h0, 16'h0003, 16'h0003, 16'h0001, 16'h0002, 16'h0007, 16'h0036,
    16'h0001};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic supply_ok = 1'b1;
  logic block_locked = 1'b0;
  logic wr_stb, rd_stb, rd_valid, array_read, program_busy, erase_busy, erase_paused_state;
  logic [7:0] addr, status_word;
  logic [15:0] wr_data, rd_data, got, d;
  int errors = 0;
  int n_checks = 0;
  int seed = 32'h7a12;
  always #5 clk_sys = ~clk_sys;
  fqs_top #(.UNIQUE_NUMBER(UNIQ)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(1'b1),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .addr(addr), .wr_data(wr_data), .supply_ok(supply_ok),
    .block_locked(block_locked), .rd_data(rd_data), .rd_valid(rd_valid),
    .array_read(array_read), .program_busy(program_busy), .erase_busy(erase_busy),
    .erase_paused_state(erase_paused_state), .status_word(status_word));
  fqs_host i_host (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .addr(addr), .wr_data(wr_data));
  function automatic logic [15:0] exp_q(input logic [7:0] a);
    return Q_TAB[a - 8'h39];
  endfunction : exp_q
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c);
    i_host.wr(8'h00, {8'h00, c});
  endtask : cmd
  task automatic wait_ready();
    for (int i = 0; i < 300 && status_word[7] !== 1'b1; i++) @(negedge clk_sys);
  endtask : wait_ready
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    errors++;
    final_report();
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    chk("status_reset", 16'h0080, {8'h00, status_word});
    i_host.rd(8'h39, got);
    chk("array_read_data", 16'h0000, got);
    $display("Test reset done");
    cmd(8'h98);
    for (int a = 8'h39; a <= 8'h52 + 20; a++) begin
      d = (a > 8'h52) ? 16'h39 + 16'(($random(seed) & 32'h7fff) % 26) : 16'(a);
      i_host.rd(d[7:0], got);
      chk("query_word", exp_q(d[7:0]), got);
    end
    i_host.rd(8'h80, got);
    chk("protect_bit0", 16'h0000, {15'h0, got[0]});
    for (int i = 0; i < 4; i++) begin
      i_host.rd(8'h81 + 8'(i), got);
      chk("unique_word", UNIQ[16*i +: 16], got);
    end
    cmd(8'h40);
    i_host.wr(8'h86, 16'h1234);
    wait_ready();
    cmd(8'h98);
    i_host.rd(8'h86, got);
    chk("otp_word", 16'h1234, got);
    $display("Test query done");
    d = 16'($random(seed));
    cmd(8'h30);
    i_host.wr(8'h20, {d[15:8], 8'h3c});
    i_host.wr(8'h21, {d[7:0], 8'h3c});
    chk("double_busy", 16'h0001, {15'h0, program_busy});
    wait_ready();
    chk("double_clean", 16'h0000, {8'h00, status_word & 8'h1a});
    cmd(8'h55);
    // The last word leaves the group of four, so a program error is due.
    for (int i = 0; i < 3; i++) i_host.wr(8'h24 + 8'(i), {d[7:0], 8'h3c});
    i_host.wr(8'h2b, {d[7:0], 8'h3c});
    wait_ready();
    chk("quad_error", 16'h0010, {8'h00, status_word & 8'h1a});
    cmd(8'h50);
    @(negedge clk_sys);
    supply_ok = 1'b0;
    block_locked = 1'b1;
    cmd(8'h40);
    i_host.wr(8'h10, 16'h0a3c);
    supply_ok = 1'b1;
    block_locked = 1'b0;
    chk("setup_errors", 16'h000a, {8'h00, status_word & 8'h0a});
    wait_ready();
    cmd(8'h40);
    i_host.wr(8'h10, 16'h0a3c);
    chk("refused_prog", 16'h0000, {15'h0, program_busy});
    cmd(8'h50);
    chk("cleared", 16'h0080, {8'h00, status_word});
    $display("Test program done");
    cmd(8'h20);
    cmd(8'hd0);
    chk("erase_busy", 16'h0001, {15'h0, erase_busy});
    cmd(8'hb0);
    cmd(8'h70);
    wait_ready();
    chk("suspended", 16'h00c0, {8'h00, status_word & 8'hc0});
    cmd(8'hff);
    chk("es_array", 16'h0001, {15'h0, array_read});
    cmd(8'hd0);
    chk("resumed", 16'h0001, {15'h0, erase_busy & ~erase_paused_state});
    wait_ready();
    chk("erase_done", 16'h0080, {8'h00, status_word & 8'hc0});
    $display("Test suspend done");
    final_report();
  end
endmodule : tb
`default_nettype wire
